// ===== omx_dmem_model.sv
// Purpose: data memory model on the far side of the executor
// Assumes: read data combinational on the address while the read strobe is high
// Notes: a released read bus shows the inverse of the last byte read
`default_nettype none
module omx_dmem_model (
    // clock
    input wire logic clk_i,
    // memory port
    input wire logic [11:0] addr_i,
    input wire logic re_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4095];
    logic [7:0] last = 8'h00;
    // no stale byte once released
    assign rdata_o = re_i ? mem[addr_i] : ~last;
    always @(posedge clk_i) begin
        if (re_i) last <= mem[addr_i];
        if (we_i) mem[addr_i] <= wdata_i;
    end
endmodule
`default_nettype wire

// ===== omx_exec.sv
// Purpose: decode and execute of the or/move/load instruction group
// Assumes: memory read data is combinational on dmem_addr_o
// Notes: one instruction cycle is four clocks, q phases from a counter
//
// How it works
// - or literal into accumulator, one cycle
// - ors and file move touch only n, z
// - or accumulator with file, d and a bits
// - d=0 writes accumulator, d=1 writes file
// - a=0 access bank, a=1 bank register
// - extended set, f<=5f uses indexed offset
// - pointer load: high part, then low byte
// - move file to destination in one cycle
// - full move: source word, destination word
// - full move reaches whole 4k space, accumulator too
// - full move two cycles, no dummy read, no flags
// - bank load keeps upper nibble zero
// - move literal to accumulator, flags kept
// - store accumulator to file, flags kept
`default_nettype none
module omx_exec (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // instruction stream
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    output logic instr_take_o,
    // data memory
    output logic [11:0] dmem_addr_o,
    output logic dmem_re_o,
    output logic dmem_we_o,
    output logic [7:0] dmem_wdata_o,
    input wire logic [7:0] dmem_rdata_i
);
    logic [1:0] q;
    omx_pkg::omx_state_t state;
    omx_pkg::omx_op_t op;
    logic [15:0] ir;
    logic [11:0] ir2;
    logic got2;
    logic [7:0] acc;
    logic [7:0] bank;
    logic [4:0] status;
    logic ext_en;
    logic [7:0] res;
    logic [11:0] ptr [omx_pkg::PTR_COUNT];

    // phase divider
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= omx_pkg::Q_DECODE;
        end else begin
            q <= q + 2'h1;
        end
    end

    wire ph_decode = q == omx_pkg::Q_DECODE;
    wire ph_read = q == omx_pkg::Q_READ;
    wire ph_proc = q == omx_pkg::Q_PROC;
    wire ph_write = q == omx_pkg::Q_WRITE;
    wire in_fetch = state == omx_pkg::ST_FETCH;
    wire in_second = state == omx_pkg::ST_SECOND;

    // opcode decode
    wire dec_or_lit = instr_i[15:8] == omx_pkg::OPC_OR_LIT;
    wire dec_or_file = instr_i[15:10] == omx_pkg::OPC_OR_FILE;
    wire dec_move_file = instr_i[15:10] == omx_pkg::OPC_MOVE_FILE;
    wire dec_store = instr_i[15:9] == omx_pkg::OPC_STORE_ACC;
    wire dec_bank = instr_i[15:8] == omx_pkg::OPC_LOAD_BANK;
    wire dec_move_lit = instr_i[15:8] == omx_pkg::OPC_MOVE_LIT;
    wire dec_full = instr_i[15:12] == omx_pkg::OPC_MOVE_FULL;
    wire dec_ptr = instr_i[15:6] == omx_pkg::OPC_LOAD_PTR && instr_i[5:4] != omx_pkg::PTR_IDX_BAD;
    omx_pkg::omx_op_t next_op;
    assign next_op = dec_or_lit ? omx_pkg::OP_OR_LIT :
                     dec_or_file ? omx_pkg::OP_OR_FILE :
                     dec_move_file ? omx_pkg::OP_MOVE_FILE :
                     dec_store ? omx_pkg::OP_STORE_ACC :
                     dec_bank ? omx_pkg::OP_LOAD_BANK :
                     dec_move_lit ? omx_pkg::OP_MOVE_LIT :
                     dec_full ? omx_pkg::OP_MOVE_FULL :
                     dec_ptr ? omx_pkg::OP_LOAD_PTR : omx_pkg::OP_NONE;

    // file address generation
    wire [7:0] f = ir[7:0];
    wire use_index = !ir[8] && ext_en && f <= omx_pkg::INDEX_LIMIT;
    wire [11:0] access_addr = f[7] ? {omx_pkg::ACCESS_HI_PAGE, f} : {4'h0, f};
    wire [11:0] idx_addr = ptr[2] + {4'h0, f};
    wire [11:0] bank_addr = {bank[3:0], f};
    wire [11:0] file_addr = ir[8] ? bank_addr : (use_index ? idx_addr : access_addr);

    wire op_or_lit = op == omx_pkg::OP_OR_LIT;
    wire op_or_file = op == omx_pkg::OP_OR_FILE;
    wire op_move_file = op == omx_pkg::OP_MOVE_FILE;
    wire op_store = op == omx_pkg::OP_STORE_ACC;
    wire op_full = op == omx_pkg::OP_MOVE_FULL;
    wire op_ptr = op == omx_pkg::OP_LOAD_PTR;
    wire op_bank = op == omx_pkg::OP_LOAD_BANK;
    wire op_move_lit = op == omx_pkg::OP_MOVE_LIT;
    wire op_dest = op_or_file || op_move_file;

    // operand read
    wire rd_needed = in_fetch && (op_dest || op_full);
    wire [11:0] rd_addr = op_full ? ir[11:0] : file_addr;
    wire rd_is_acc = dmem_addr_o == omx_pkg::ACC_ADDR;
    wire [7:0] src = rd_is_acc ? acc : dmem_rdata_i;
    wire [7:0] next_res = op_or_lit ? (acc | ir[7:0]) :
                          op_or_file ? (acc | src) :
                          (op_move_file || op_full) ? src : res;

    // write-back
    wire exec1 = ph_write && in_fetch;
    wire exec2 = ph_write && in_second && got2;
    wire to_file = exec1 && (op_store || (op_dest && ir[9]));
    wire full_write = exec2 && op_full;
    wire file_write = to_file || full_write;
    wire [11:0] wr_addr = exec2 ? ir2 : file_addr;
    wire [7:0] wr_data = (op_store && !exec2) ? acc : res;
    wire wr_hits_acc = wr_addr == omx_pkg::ACC_ADDR;
    wire acc_direct = exec1 && (op_or_lit || op_move_lit || (op_dest && !ir[9]));
    wire core_acc_wr = acc_direct || (file_write && wr_hits_acc);
    wire [7:0] core_acc_val = op_move_lit ? ir[7:0] : wr_data;
    wire flags_upd = exec1 && (op_or_lit || op_dest);
    wire bank_wr = exec1 && op_bank;
    wire ptr_hi_wr = exec1 && op_ptr;
    wire ptr_lo_wr = exec2 && op_ptr;
    wire [1:0] ptr_idx = ir[5:4];
    wire go_second = exec1 && (op_ptr || op_full);
    wire take = ph_decode && instr_valid_i && (in_fetch || !got2);

    // sequencer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= omx_pkg::ST_FETCH;
            op <= omx_pkg::OP_NONE;
            ir <= 16'h0000;
            ir2 <= 12'h000;
            got2 <= 1'h0;
            instr_take_o <= 1'h0;
        end else begin
            instr_take_o <= take;
            if (ph_decode && in_fetch) begin
                op <= instr_valid_i ? next_op : omx_pkg::OP_NONE;
                ir <= instr_i;
            end
            if (take && in_second) begin
                ir2 <= instr_i[11:0];
                got2 <= 1'h1;
            end
            if (go_second) begin
                state <= omx_pkg::ST_SECOND;
            end else if (exec2) begin
                state <= omx_pkg::ST_FETCH;
                got2 <= 1'h0;
            end
        end
    end

    // result latch in the process phase
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            res <= 8'h00;
        end else if (ph_proc && in_fetch) begin
            res <= next_res;
        end
    end

    // data memory port
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dmem_addr_o <= 12'h000;
            dmem_re_o <= 1'h0;
            dmem_we_o <= 1'h0;
            dmem_wdata_o <= 8'h00;
        end else begin
            dmem_re_o <= ph_read && rd_needed && rd_addr != omx_pkg::ACC_ADDR;
            dmem_we_o <= file_write && !wr_hits_acc;
            if (ph_read && rd_needed) begin
                dmem_addr_o <= rd_addr;
            end else if (file_write) begin
                dmem_addr_o <= wr_addr;
                dmem_wdata_o <= wr_data;
            end
        end
    end

    // apb decode
    wire apb_setup = psel_i && penable_i && !pready_o;
    wire apb_wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    wire hit_ctrl = paddr_i == omx_pkg::OFF_CTRL;
    wire hit_acc = paddr_i == omx_pkg::OFF_ACC;
    wire hit_bank = paddr_i == omx_pkg::OFF_BANK;
    wire hit_status = paddr_i == omx_pkg::OFF_STATUS;
    wire hit_core = paddr_i == omx_pkg::OFF_CORE;
    wire [omx_pkg::PTR_COUNT-1:0] hit_ptr;
    wire [31:0] ptr_rd [omx_pkg::PTR_COUNT];
    wire wr_acc = apb_wr && hit_acc;
    wire wr_status = apb_wr && hit_status;
    wire wr_bank = apb_wr && hit_bank;
    wire [31:0] core_word = {21'h000000, op, state};
    wire [31:0] rd_word = hit_ctrl ? {31'h00000000, ext_en} :
                          hit_acc ? {24'h000000, acc} :
                          hit_bank ? {24'h000000, bank} :
                          hit_status ? {27'h0000000, status} :
                          hit_core ? core_word :
                          ptr_rd[0] | ptr_rd[1] | ptr_rd[2];
    wire mapped = hit_ctrl || hit_acc || hit_bank || hit_status || hit_core || (|hit_ptr);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'h0;
            pslverr_o <= 1'h0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup && !mapped;
            if (apb_setup) begin
                prdata_o <= mapped ? rd_word : 32'h00000000;
            end
        end
    end

    // pointer registers
    for (genvar i = 0; i < omx_pkg::PTR_COUNT; i++) begin : g_ptr
        localparam logic [7:0] PTR_OFF = omx_pkg::OFF_PTR0 + 8'(i) * omx_pkg::OFF_PTR_STEP;
        assign hit_ptr[i] = paddr_i == PTR_OFF;
        assign ptr_rd[i] = hit_ptr[i] ? {20'h00000, ptr[i]} : 32'h00000000;
        wire sel_core = ptr_idx == 2'(i);
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                ptr[i] <= omx_pkg::RST_PTR;
            end else if (ptr_hi_wr && sel_core) begin
                ptr[i][11:8] <= ir[3:0];
            end else if (ptr_lo_wr && sel_core) begin
                ptr[i][7:0] <= ir2[7:0];
            end else if (apb_wr && hit_ptr[i]) begin
                ptr[i] <= pwdata_i[11:0];
            end
        end
    end

    // status flags, instructions move only n and z and override the bus, a bus write loads all five in any other cycle
    logic [4:0] next_status;
    always_comb begin
        next_status = status;
        if (flags_upd) begin
            next_status[omx_pkg::STAT_N] = res[7];
            next_status[omx_pkg::STAT_Z] = res == 8'h00;
        end else if (wr_status) begin
            next_status = pwdata_i[4:0];
        end
    end

    // core writes win over the bus
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc <= omx_pkg::RST_ACC;
            bank <= omx_pkg::RST_BANK;
            status <= omx_pkg::RST_STATUS;
            ext_en <= omx_pkg::RST_EXT;
        end else begin
            status <= next_status;
            if (core_acc_wr) begin
                acc <= core_acc_val;
            end else if (wr_acc) begin
                acc <= pwdata_i[7:0];
            end
            if (bank_wr) begin
                bank <= {4'h0, ir[3:0]};
            end else if (wr_bank) begin
                bank <= {4'h0, pwdata_i[3:0]};
            end
            if (apb_wr && hit_ctrl) begin
                ext_en <= pwdata_i[omx_pkg::CTRL_EXT_BIT];
            end
        end
    end

    // checks
    chk_phase_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ph_write |=> ph_decode ##1 ph_read ##1 ph_proc)
        else $error("q phases out of order");

    chk_or_literal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ph_proc && in_fetch && op_or_lit) |-> ##2 acc == ($past(acc, 2) | $past(ir[7:0], 2)))
        else $error("or literal result wrong");

    chk_flags_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (flags_upd && !wr_status) |=> status[3] == $past(status[3]) && status[1:0] == $past(status[1:0])
            && status[omx_pkg::STAT_Z] == ($past(res) == 8'h00))
        else $error("or/move flag update wrong");

    chk_dest_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (exec1 && op_dest && !ir[9]) |=> !dmem_we_o && acc == $past(res))
        else $error("d=0 did not go to accumulator");

    chk_access_bank: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ph_read && rd_needed && op_dest && !ir[8] && !ext_en)
            |=> dmem_addr_o == {(f[7] ? 4'hF : 4'h0), f})
        else $error("access bank address wrong");

    chk_indexed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ph_read && rd_needed && op_dest && !ir[8] && ext_en && f <= 8'h5F)
            |=> dmem_addr_o == $past(ptr[2]) + {4'h0, $past(f)})
        else $error("indexed offset address wrong");

    chk_ptr_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ptr_hi_wr && ptr_idx == 2'h2) |=> ptr[2][11:8] == $past(ir[3:0]) && in_second)
        else $error("pointer high part not loaded");

    chk_full_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (full_write && ir2 != 12'hFE8 && !wr_status)
            |=> dmem_we_o && dmem_addr_o == $past(ir2) && $stable(status) && in_fetch)
        else $error("full move write wrong");

    chk_no_dummy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        in_second |-> !dmem_re_o)
        else $error("dummy read in second cycle");

    chk_bank_upper: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        bank[7:4] == 4'h0)
        else $error("bank upper nibble not zero");

    chk_lit_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (exec1 && (op_move_lit || op_store || op_bank) && !wr_status) |=> $stable(status))
        else $error("flags changed by move");

    chk_store_acc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (exec1 && op_store && file_addr != 12'hFE8) |=> dmem_we_o && dmem_wdata_o == $past(acc))
        else $error("accumulator store wrong");
endmodule
`default_nettype wire

// ===== omx_pkg.sv
// Purpose: shared constants and types for the or/move instruction executor
// Assumes: 100 MHz core clock, four q phases per instruction cycle
// Notes: register offsets are byte addresses on the apb slave
`default_nettype none
package omx_pkg;
    // apb register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_BANK = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_PTR0 = 8'h10;
    localparam logic [7:0] OFF_PTR_STEP = 8'h04;
    localparam logic [7:0] OFF_CORE = 8'h1C;
    // field positions
    localparam int unsigned CTRL_EXT_BIT = 0;
    localparam int unsigned STAT_C = 0;
    localparam int unsigned STAT_DC = 1;
    localparam int unsigned STAT_Z = 2;
    localparam int unsigned STAT_OV = 3;
    localparam int unsigned STAT_N = 4;
    // reset values
    localparam logic RST_EXT = 1'h0;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [4:0] RST_STATUS = 5'h00;
    localparam logic [11:0] RST_PTR = 12'h000;
    // data space map
    localparam logic [11:0] ACC_ADDR = 12'hFE8;
    localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam int unsigned PTR_COUNT = 3;
    // q phases, one clock each
    localparam logic [1:0] Q_DECODE = 2'h0;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_PROC = 2'h2;
    localparam logic [1:0] Q_WRITE = 2'h3;
    // opcode prefixes
    localparam logic [7:0] OPC_OR_LIT = 8'h09;
    localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
    localparam logic [7:0] OPC_MOVE_LIT = 8'h0E;
    localparam logic [5:0] OPC_OR_FILE = 6'h04;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
    localparam logic [6:0] OPC_STORE_ACC = 7'h37;
    localparam logic [3:0] OPC_MOVE_FULL = 4'hC;
    localparam logic [9:0] OPC_LOAD_PTR = 10'h3B8;
    localparam logic [1:0] PTR_IDX_BAD = 2'h3;

    typedef enum logic [8:0] {
        OP_NONE = 9'h001,
        OP_OR_LIT = 9'h002,
        OP_OR_FILE = 9'h004,
        OP_LOAD_PTR = 9'h008,
        OP_MOVE_FILE = 9'h010,
        OP_MOVE_FULL = 9'h020,
        OP_LOAD_BANK = 9'h040,
        OP_MOVE_LIT = 9'h080,
        OP_STORE_ACC = 9'h100
    } omx_op_t;

    typedef enum logic [1:0] {
        ST_FETCH = 2'h1,
        ST_SECOND = 2'h2
    } omx_state_t;
endpackage
`default_nettype wire

// ===== omx_tb.sv
// Purpose: self-checking bench for the or/move instruction executor
// Assumes: apb reads noted in a queue, checked when the answer comes
// Notes: random literals and memory bytes from a fixed seed
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, instr_valid = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, instr_take, dmem_re, dmem_we;
    logic [15:0] instr = 16'h0000;
    logic [11:0] dmem_addr;
    logic [7:0] dmem_wdata, dmem_rdata, acc, k, v, f;
    logic [4:0] st;
    logic [32:0] exp_q[$];
    int failures = 0, n_compared = 0, cyc = 0, n_re = 0;
    integer seed;
    omx_exec omx_exec_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .instr_i(instr), .instr_valid_i(instr_valid), .instr_take_o(instr_take),
        .dmem_addr_o(dmem_addr), .dmem_re_o(dmem_re), .dmem_we_o(dmem_we), .dmem_wdata_o(dmem_wdata),
        .dmem_rdata_i(dmem_rdata));
    omx_dmem_model omx_dmem_model_inst (.clk_i(clk_i), .addr_i(dmem_addr), .re_i(dmem_re),
        .we_i(dmem_we), .wdata_i(dmem_wdata), .rdata_o(dmem_rdata));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] e);
        n_compared++;
        if (seen !== e) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, e);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        if (!wr) exp_q.push_back(e);
        @(posedge clk_i);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'h1;
        // hold until pready is sampled high; only the bench timeout ends a hang
        do @(posedge clk_i); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0, {1'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, 33'h0);
    endtask
    task automatic issue(input logic [15:0] w);
        @(posedge clk_i);
        instr <= w;
        instr_valid <= 1'h1;
        // word stays offered until the take pulse is sampled high
        do @(posedge clk_i); while (instr_take !== 1'h1);
        instr_valid <= 1'h0;
        instr <= ~w;
    endtask
    task automatic exec(input logic [15:0] w);
        issue(w);
        repeat (5) @(posedge clk_i);
    endtask
    task automatic mchk(input logic [11:0] a, input logic [7:0] e);
        chk({25'h0, omx_dmem_model_inst.mem[a]}, {25'h0, e});
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (dmem_re === 1'h1) n_re++;
        if (psel && penable && pready === 1'h1 && !pwrite) begin
            if (exp_q.size() == 0) chk(33'h0, 33'h1);
            else chk({pslverr, prdata}, exp_q.pop_front());
        end
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        seed = 32'h3EAD;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        rd(omx_pkg::OFF_CTRL, 32'h0);
        rd(omx_pkg::OFF_ACC, 32'h0);
        rd(omx_pkg::OFF_BANK, 32'h0);
        rd(omx_pkg::OFF_STATUS, 32'h0);
        rd(omx_pkg::OFF_PTR0, 32'h0);
        apb(1'h0, 8'h20, 32'h0, {1'h1, 32'h0});
        st = 5'h0B;
        wr(omx_pkg::OFF_STATUS, {27'h0, st});
        for (int i = 0; i < 5; i++) begin
            k = (i == 0) ? 8'h00 : 8'($random(seed));
            v = (i == 0) ? 8'h00 : 8'($random(seed));
            exec({omx_pkg::OPC_MOVE_LIT, k});
            exec({omx_pkg::OPC_OR_LIT, v});
            acc = k | v;
            st = {acc[7], st[3], acc == 8'h00, st[1:0]};
            rd(omx_pkg::OFF_ACC, {24'h0, acc});
            rd(omx_pkg::OFF_STATUS, {27'h0, st});
        end
        exec({omx_pkg::OPC_MOVE_LIT, 8'h80});
        rd(omx_pkg::OFF_ACC, 32'h80);
        rd(omx_pkg::OFF_STATUS, {27'h0, st});
        exec({omx_pkg::OPC_LOAD_BANK, 8'hF5});
        rd(omx_pkg::OFF_BANK, 32'h05);
        f = 8'($random(seed));
        v = 8'($random(seed));
        omx_dmem_model_inst.mem[{4'h5, f}] = v;
        omx_dmem_model_inst.mem[{4'h5, f ^ 8'h01}] = 8'h00;
        exec({omx_pkg::OPC_OR_FILE, 1'h1, 1'h1, f});
        mchk({4'h5, f}, v | 8'h80);
        rd(omx_pkg::OFF_ACC, 32'h80);
        exec({omx_pkg::OPC_MOVE_FILE, 1'h0, 1'h1, f ^ 8'h01});
        st = {1'h0, st[3], 1'h1, st[1:0]};
        rd(omx_pkg::OFF_ACC, 32'h00);
        rd(omx_pkg::OFF_STATUS, {27'h0, st});
        exec({omx_pkg::OPC_MOVE_LIT, 8'h3C});
        exec({omx_pkg::OPC_STORE_ACC, 1'h0, 8'h20});
        mchk(12'h020, 8'h3C);
        exec({omx_pkg::OPC_STORE_ACC, 1'h0, 8'h90});
        mchk(12'hF90, 8'h3C);
        rd(omx_pkg::OFF_STATUS, {27'h0, st});
        wr(omx_pkg::OFF_CTRL, 32'h1);
        issue({omx_pkg::OPC_LOAD_PTR, 2'h2, 4'h3});
        exec(16'h00AB);
        rd(omx_pkg::OFF_PTR0 + 8'h08, 32'h3AB);
        exec({omx_pkg::OPC_STORE_ACC, 1'h0, 8'h10});
        mchk(12'h3BB, 8'h3C);
        exec({omx_pkg::OPC_STORE_ACC, 1'h0, 8'h60});
        mchk(12'h060, 8'h3C);
        exec({omx_pkg::OPC_MOVE_LIT, 8'h41});
        exec({omx_pkg::OPC_OR_FILE, 1'h0, 1'h0, 8'h10});
        st = {1'h0, st[3], 1'h0, st[1:0]};
        rd(omx_pkg::OFF_ACC, 32'h7D);
        rd(omx_pkg::OFF_STATUS, {27'h0, st});
        wr(omx_pkg::OFF_CTRL, 32'h0);
        exec({omx_pkg::OPC_MOVE_FILE, 1'h0, 1'h0, 8'h20});
        rd(omx_pkg::OFF_ACC, 32'h3C);
        v = 8'($random(seed));
        omx_dmem_model_inst.mem[12'hA51] = v;
        // destinations stay clear of pc and return-stack bytes
        n_re = 0;
        issue({4'hC, 12'hA51});
        exec({4'hF, 12'h123});
        mchk(12'h123, v);
        chk({32'h0, n_re == 1}, 33'h1);
        rd(omx_pkg::OFF_STATUS, {27'h0, st});
        issue({4'hC, 12'hA51});
        repeat (6) @(posedge clk_i);
        exec({4'hF, omx_pkg::ACC_ADDR});
        rd(omx_pkg::OFF_ACC, {24'h0, v});
        n_re = 0;
        issue({4'hC, omx_pkg::ACC_ADDR});
        exec({4'hF, 12'h7FF});
        mchk(12'h7FF, v);
        chk({32'h0, n_re == 0}, 33'h1);
        end_sim();
    end
endmodule
`default_nettype wire
